//--- hw/iowdt_pkg.sv
// Package of constants and types for the I/O port watchdog timer
`default_nettype none
package iowdt_pkg;
    localparam logic [15:0] IOWDT_PORT_ADDR = 16'h0443;
    localparam logic [7:0] IOWDT_CODE_MIN = 8'h01;
    localparam logic [7:0] IOWDT_CODE_MAX = 8'h3E;
    localparam logic [7:0] IOWDT_CODE_RESET = 8'h00;
    localparam int IOWDT_CLK_HZ = 100_000_000;
    localparam int IOWDT_TICK_SEC = 1;
    localparam int IOWDT_TICK_CYCLES = IOWDT_CLK_HZ * IOWDT_TICK_SEC;
    localparam int IOWDT_PRESC_W = 27;
    localparam int IOWDT_PULSE_CYCLES = 16;
    localparam logic [5:0] IOWDT_PULSE_W_ONE = 6'h01;
    typedef enum logic {
        IOWDT_ACT_RESET,
        IOWDT_ACT_IRQ
    } iowdt_action_t;
endpackage : iowdt_pkg
`default_nettype wire

//--- hw/iowdt_tick_if.sv
// Interface carrying the one-second timebase between the watchdog modules
`default_nettype none
interface iowdt_tick_if;
    logic run;
    logic tick;
    modport gen (input run, output tick);
    modport use_tick (output run, input tick);
endinterface : iowdt_tick_if
`default_nettype wire

//--- hw/iowdt_tick.sv
// One-second tick generator for the watchdog
`default_nettype none
module iowdt_tick
    import iowdt_pkg::*;
#(
    parameter int TICK_CYCLES = IOWDT_TICK_CYCLES
) (
    input wire logic core_clk, // Core clock
    input wire logic rst_n, // Synchronised reset
    iowdt_tick_if.gen tk // Run in, tick out
);
    typedef struct packed {
        logic [IOWDT_PRESC_W-1:0] cnt;
        logic tick;
    } iowdt_tick_state_t;
    iowdt_tick_state_t s_q, s_d;

    localparam logic [IOWDT_PRESC_W-1:0] LAST = IOWDT_PRESC_W'(TICK_CYCLES - 1);

    // Prescaler restarts whenever the countdown is (re)armed
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!tk.run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + IOWDT_PRESC_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tk.tick = s_q.tick;

    tick_spacing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.tick |=> !s_q.tick)
        else $error("tick lasted more than one cycle");
endmodule : iowdt_tick
`default_nettype wire

//--- hw/iowdt_top.sv
// I/O port watchdog timer: port decode, countdown and expiry action
`default_nettype none
module iowdt_top
    import iowdt_pkg::*;
#(
    parameter int TICK_CYCLES = IOWDT_TICK_CYCLES
) (
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [15:0] io_addr, // I/O address, synchronous to core_clk
    input wire logic io_wr, // One-cycle write strobe
    input wire logic io_rd, // One-cycle read strobe
    input wire logic [7:0] io_wdata, // Write data
    output logic [7:0] io_rdata, // Read data, loaded code captured by the last port read
    output logic io_sel, // Port 443h addressed, combinational
    input wire logic action_sel, // 0 reset host, 1 interrupt
    output logic host_reset, // Host reset pulse, active high
    output logic irq, // Interrupt request, level until disarm or rewrite
    output logic armed // Countdown is running
);
    typedef struct packed {
        logic armed;
        logic [5:0] secs;
        logic [7:0] code;
        logic [7:0] rdata;
        logic [5:0] pulse;
        logic irq;
        logic [39:0] elapsed; // Cycles since the last load, read only by the timing check
    } iowdt_state_t;
    iowdt_state_t s_q, s_d;

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic wr_hit;
    logic rd_hit;
    logic code_ok;
    logic expire;

    iowdt_tick_if tk ();

    iowdt_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tk(tk)
    );

    // Two-stage release of the reset; assertion stays asynchronous
    // Kept out of the state struct: it is cleared by the pin, not by its own output
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign io_sel = (io_addr == IOWDT_PORT_ADDR);
    assign wr_hit = io_sel && io_wr;
    assign rd_hit = io_sel && io_rd;
    assign code_ok = (io_wdata >= IOWDT_CODE_MIN) && (io_wdata <= IOWDT_CODE_MAX);
    assign expire = s_q.armed && tk.tick && (s_q.secs == IOWDT_PULSE_W_ONE);

    // Read wins over a write in the same cycle: disarming is the safe outcome
    always_comb begin
        s_d = s_q;
        // Elapsed cycles feed only the timing check, so synthesis drops them
        s_d.elapsed = s_q.armed ? s_q.elapsed + 40'h1 : '0;
        if (s_q.pulse != '0) begin
            s_d.pulse = s_q.pulse - 6'h01;
        end
        if (rd_hit) begin
            s_d.armed = 1'b0;
            s_d.irq = 1'b0;
            s_d.rdata = s_q.code;
        end else if (wr_hit && code_ok) begin
            s_d.armed = 1'b1;
            s_d.secs = io_wdata[5:0];
            s_d.code = io_wdata;
            s_d.elapsed = 40'h1;
            s_d.irq = 1'b0;
        end else if (expire) begin
            s_d.armed = 1'b0;
            if (iowdt_action_t'(action_sel) == IOWDT_ACT_IRQ) begin
                s_d.irq = 1'b1;
            end else begin
                s_d.pulse = 6'(IOWDT_PULSE_CYCLES);
            end
        end else if (s_q.armed && tk.tick) begin
            s_d.secs = s_q.secs - 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.armed <= 1'b0;
            s_q.secs <= '0;
            s_q.code <= IOWDT_CODE_RESET;
            s_q.rdata <= IOWDT_CODE_RESET;
            s_q.pulse <= '0;
            s_q.irq <= 1'b0;
            s_q.elapsed <= '0;
        end else begin
            s_q.armed <= s_d.armed;
            s_q.secs <= s_d.secs;
            s_q.code <= s_d.code;
            s_q.rdata <= s_d.rdata;
            s_q.pulse <= s_d.pulse;
            s_q.irq <= s_d.irq;
            s_q.elapsed <= s_d.elapsed;
        end
    end

    // Prescaler only runs while armed, and restarts on every accepted write
    assign tk.run = s_q.armed && !(wr_hit && code_ok);

    assign io_rdata = s_q.rdata;
    assign host_reset = (s_q.pulse != '0);
    assign irq = s_q.irq;
    assign armed = s_q.armed;

    arm_on_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_hit && code_ok && !rd_hit) |=> (armed && s_q.secs == $past(io_wdata[5:0])))
        else $error("valid write did not arm the countdown");

    bad_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_hit && !code_ok && !rd_hit && !expire && !(armed && tk.tick)) |=> $stable(s_q.secs))
        else $error("out-of-range code changed the countdown");

    read_disarm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit |=> (!armed && !irq))
        else $error("port read did not disarm");

    sec_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (armed && tk.tick && s_q.secs > 6'h01 && !io_wr && !io_rd)
        |=> (s_q.secs == $past(s_q.secs) - 6'h01))
        else $error("countdown did not step once per second");

    expire_act_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (expire && !rd_hit && !(wr_hit && code_ok)) |=> (host_reset || irq))
        else $error("expiry raised neither reset nor interrupt");

    reset_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(host_reset) |-> host_reset [*8])
        else $error("host reset pulse too short");

    no_act_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!armed && !host_reset && !irq) |=> !irq)
        else $error("interrupt raised while disarmed");

    restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_hit && code_ok && !rd_hit) |=> !tk.tick)
        else $error("rewrite did not restart the second timebase");

    // The expiry interrupt holds its level until software reacts; the host reset pulse ends by itself
    irq_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq && !rd_hit && !(wr_hit && code_ok))
        |=> irq)
        else $error("interrupt dropped without a read or rewrite");

    expire_disarm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (expire && !rd_hit && !(wr_hit && code_ok))
        |=> !armed)
        else $error("countdown still armed after expiry");

    pulse_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(host_reset)
        |-> ($past(host_reset, IOWDT_PULSE_CYCLES) && !$past(host_reset, IOWDT_PULSE_CYCLES + 1)))
        else $error("host reset pulse length wrong");

    // A valid rewrite both restarts the count and withdraws a raised interrupt
    irq_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq && wr_hit && code_ok && !rd_hit)
        |=> !irq)
        else $error("valid rewrite left the interrupt raised");

    quiet_disarm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !armed
        |=> (!$rose(host_reset) && !$rose(irq)))
        else $error("expiry action while disarmed");

    read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit
        |=> (io_rdata == $past(s_q.code)))
        else $error("read did not return the loaded code");

    code_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        armed
        |-> (s_q.code >= IOWDT_CODE_MIN && s_q.code <= IOWDT_CODE_MAX))
        else $error("armed with an out-of-range code");

    code_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_hit && !code_ok)
        |=> $stable(s_q.code))
        else $error("out-of-range code was loaded");

    other_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_wr && !io_sel && !expire && !(armed && tk.tick))
        |=> ($stable(s_q.secs) && $stable(armed)))
        else $error("write to another port touched the countdown");

    idle_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(armed)
        |-> !tk.tick)
        else $error("second tick while disarmed");

    secs_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        armed
        |-> (s_q.secs != 6'h00 && s_q.secs <= s_q.code[5:0]))
        else $error("seconds left outside the loaded interval");

    // Last tick lands one cycle after code times the prescaler period
    timeout_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        expire
        |-> (s_q.elapsed == 40'(s_q.code) * 40'(TICK_CYCLES) + 40'h1))
        else $error("expiry time does not match the code");
endmodule : iowdt_top
`default_nettype wire

//--- testbench/test_iowdt_top.sv
// Self-checking bench for the I/O port watchdog timer
`default_nettype none
module test_iowdt_top
    import iowdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 20;
    logic core_clk = 1'b0, resetn = 1'b0, io_wr = 1'b0, io_rd = 1'b0, action_sel = 1'b0;
    logic [15:0] io_addr = IOWDT_PORT_ADDR;
    logic [7:0] io_wdata = 8'h00, io_rdata, r;
    logic io_sel, host_reset, irq, armed, hr_p = 1'b0, irq_p = 1'b0, rd_seen = 1'b0;
    logic [16:0] lf = 17'h12710;
    logic [8:0] notes[$];
    int err_count = 0, cmp_count = 0, cyc = 0, t0 = 0, exp_n = 0;
    iowdt_top #(.TICK_CYCLES(TK)) u_iowdt_top (.core_clk(core_clk), .resetn(resetn),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_sel(io_sel), .action_sel(action_sel),
        .host_reset(host_reset), .irq(irq), .armed(armed));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rd_seen <= io_rd & io_sel;
    end
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    // Expiry notes carry the action bit and the whole seconds since the last load
    always @(negedge core_clk) begin
        logic [8:0] n;
        n = notes.size() > 0 ? notes.pop_front() : 9'h1FF;
        if ((host_reset === 1'b1 && !hr_p) || (irq === 1'b1 && !irq_p)) begin
            check("expiry", {irq, 8'((cyc - t0) / TK)}, n);
            exp_n++;
        end else if (rd_seen) begin
            check("io_rdata", {1'b0, io_rdata}, n);
        end else if (n != 9'h1FF) begin
            notes.push_front(n);
        end
        hr_p = host_reset === 1'b1;
        irq_p = irq === 1'b1;
    end
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_wr <= w;
        io_rd <= ~w;
        io_wdata <= d;
        @(posedge core_clk);
        t0 = w ? cyc : t0;
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_addr <= IOWDT_PORT_ADDR;
    endtask
    task automatic wait_exp();
        int n;
        n = exp_n;
        for (int i = 0; i < 1500 && exp_n == n; i++) begin
            @(posedge core_clk);
        end
        if (exp_n == n) begin
            check("expiry wait", 9'h000, 9'h001);
            complete_run();
        end
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        check("run time", 9'h000, 9'h001);
        complete_run();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check("reset state", {armed, io_rdata}, 9'h000);
        check("io_sel", {8'h00, io_sel}, 9'h001);
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h00);
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h3F);
        acc(16'h0442, 1'b1, 8'h05);
        @(negedge core_clk);
        check("armed", {8'h00, armed}, 9'h000);
        @(posedge core_clk);
        io_addr <= 16'h0442;
        @(negedge core_clk);
        check("io_sel", {8'h00, io_sel}, 9'h000);
        notes.push_back(9'h002);
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h02);
        wait_exp();
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h03);
        repeat (30) @(posedge core_clk);
        notes.push_back(9'h002);
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h02);
        wait_exp();
        // Random codes, interrupt action; the second write also withdraws the first interrupt
        action_sel <= 1'b1;
        repeat (2) begin
            lf = lfsr_next(lf);
            r = 8'((lf % 62) + 1);
            notes.push_back({1'b1, r});
            acc(IOWDT_PORT_ADDR, 1'b1, r);
            wait_exp();
        end
        notes.push_back({1'b0, r});
        acc(IOWDT_PORT_ADDR, 1'b0, 8'h00);
        @(negedge core_clk);
        check("irq", {8'h00, irq}, 9'h000);
        // A reset in mid-count must leave the timer disarmed
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h05);
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check("reset state", {armed, io_rdata}, 9'h000);
        acc(IOWDT_PORT_ADDR, 1'b1, 8'h3E);
        notes.push_back(9'h03E);
        acc(IOWDT_PORT_ADDR, 1'b0, 8'h00);
        repeat (1400) @(posedge core_clk);
        @(negedge core_clk);
        check("disarmed", {6'h00, armed, host_reset, irq}, 9'h000);
        check("notes left", 9'(notes.size()), 9'h000);
        complete_run();
    end
endmodule // test_iowdt_top
`default_nettype wire
